// ===== orbt_pkg.sv
package orbt_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned PORT_W = 8;
    localparam int unsigned SNAP_W = 16;
    localparam int unsigned FIFO_DEPTH = 4;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_SNAP = 8'h08;
    localparam logic [7:0] REG_SIGNATURE = 8'h0c;
    localparam logic [7:0] REG_STORED = 8'h10;
    localparam logic [7:0] REG_TEST_OUT = 8'h14;

    typedef enum logic [2:0] {
        ORBT_IDX_CTRL = 3'b000,
        ORBT_IDX_STATUS = 3'b001,
        ORBT_IDX_SNAP = 3'b010,
        ORBT_IDX_SIGNATURE = 3'b011,
        ORBT_IDX_STORED = 3'b100,
        ORBT_IDX_TEST_OUT = 3'b101,
        ORBT_IDX_NONE = 3'b111
    } orbt_idx_t;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned CTRL_SAMPLE_BIT = 0;
    localparam int unsigned CTRL_PSA_BIT = 1;
    localparam int unsigned CTRL_OUTPUT_PSEUDORANDOM_PATTERNS_BIT = 2;
    localparam int unsigned CTRL_SELFTEST_BIT = 3;
    localparam int unsigned STAT_NOT_EMPTY_BIT = 0;
    localparam int unsigned STAT_FULL_BIT = 1;
    localparam int unsigned STAT_TEST_BIT = 2;
    localparam int unsigned STAT_PENDING_BIT = 3;

    // ------------------------------------------------------------
    // reset values and constants
    // ------------------------------------------------------------
    localparam logic [15:0] SIG_RESET = 16'h0000;
    localparam logic [15:0] OUTPUT_PSEUDORANDOM_PATTERNS_SEED = 16'h0001;
    localparam logic [15:0] LFSR_TAPS = 16'hb400;
    localparam logic [15:0] TEST_OUT_RESET = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : orbt_pkg

// ===== orbt_fifo_if.sv
interface orbt_fifo_if #(
    parameter int unsigned WIDTH = 16
);
    logic push_valid;
    logic push_ready;
    logic [WIDTH-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [WIDTH-1:0] pop_data;

    modport fill (output push_valid, output push_data, input push_ready,
                  input pop_valid, input pop_data, output pop_ready);
    modport store (input push_valid, input push_data, output push_ready,
                   output pop_valid, output pop_data, input pop_ready);
endinterface : orbt_fifo_if

// ===== orbt_fifo.sv
module orbt_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    orbt_fifo_if.store q
);
    localparam int unsigned PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
    } orbt_fifo_state_t;

    orbt_fifo_state_t s_r;
    orbt_fifo_state_t s_nxt;
    logic do_push;
    logic do_pop;

    assign q.push_ready = (s_r.cnt != (PW+1)'(DEPTH));
    assign q.pop_valid = (s_r.cnt != '0);
    assign q.pop_data = s_r.mem[s_r.rp];
    assign do_push = q.push_valid && q.push_ready;
    assign do_pop = q.pop_valid && q.pop_ready;

    always_comb begin
        s_nxt = s_r;
        if (do_push) begin
            s_nxt.mem[s_r.wp] = q.push_data;
            s_nxt.wp = (s_r.wp == PW'(DEPTH - 1)) ? '0 : s_r.wp + PW'(1);
        end
        if (do_pop) begin
            s_nxt.rp = (s_r.rp == PW'(DEPTH - 1)) ? '0 : s_r.rp + PW'(1);
        end
        if (do_push && !do_pop) begin
            s_nxt.cnt = s_r.cnt + (PW+1)'(1);
        end else if (do_pop && !do_push) begin
            s_nxt.cnt = s_r.cnt - (PW+1)'(1);
        end
        if (!aresetn) begin
            s_nxt.wp = '0;
            s_nxt.rp = '0;
            s_nxt.cnt = '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || clk_en) begin
            s_r <= s_nxt;
        end
    end
endmodule : orbt_fifo

// ===== orbt_transceiver.sv
// What this block does
// RULE_01: enable low drives A to B when flow high, B to A when low.
// RULE_02: enable high floats both A and B sides.
// RULE_03: rising A-to-B capture clock stores A pins into A register.
// RULE_04: B select low sends live A data to B.
// RULE_05: B select high sends stored A data to B.
// RULE_06: B-to-A path mirrors: B clock stores B, A select picks live/stored.
// RULE_07: storage loads on every capture edge, whatever enable and flow say.
// RULE_08: eight bits per side, one storage bit per line each way.
// RULE_09: test mode inhibits normal function; test logic drives and watches pins.
// RULE_10: test port activity outside test mode leaves normal function alone.
// RULE_11: snapshot sampling and boundary self-test without disturbing normal use.
// RULE_12: signature compaction on inputs, pseudorandom patterns on outputs.
// RULE_13: test activity follows the four-wire test port, driven by the tester.
// RULE_14: test inputs sampled on test clock rise, test output changes on fall.
// RULE_15: while test controller is in reset, test logic is disabled.
// RULE_16: storage registers have no reset; undefined until first capture edge.
module orbt_transceiver (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [7:0] a_port_bits_in,
    output logic [7:0] a_port_bits_out,
    output logic a_port_bits_oe_n,
    input wire logic [7:0] b_port_bits_in,
    output logic [7:0] b_port_bits_out,
    output logic b_port_bits_oe_n,
    input wire logic output_enable_n,
    input wire logic flow_a_to_b,
    input wire logic a_to_b_capture_clock,
    input wire logic b_to_a_capture_clock,
    input wire logic b_output_source_select,
    input wire logic a_output_source_select,
    input wire logic test_clock,
    input wire logic test_mode_select,
    input wire logic test_data_in,
    output logic test_data_out,
    output logic test_data_out_oe_n,
    input wire logic tap_in_reset_state,
    input wire logic test_mode_request,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] a_store, b_store, a_out, b_out;
        logic clk_ab_q, clk_ba_q, tck_q;
        logic a_oe_n, b_oe_n, tdo, tdo_oe_n;
        logic [15:0] scan_sr, test_out, sig, output_pseudorandom_patterns;
        logic psa_en, output_pseudorandom_patterns_en, selftest, sample_pend;
        logic aw_got, w_got;
        logic [7:0] awaddr_q;
        logic [31:0] wdata_q, rdata;
        logic [3:0] wstrb_q;
        logic awready, wready, bvalid, arready, rvalid;
        logic [1:0] bresp, rresp;
    } orbt_state_t;

    orbt_state_t s_r;
    orbt_state_t s_nxt;

    orbt_fifo_if #(.WIDTH(orbt_pkg::SNAP_W)) snap_q ();

    orbt_fifo #(
        .WIDTH(orbt_pkg::SNAP_W),
        .DEPTH(orbt_pkg::FIFO_DEPTH)
    ) u_snap_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .q(snap_q)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic orbt_pkg::orbt_idx_t reg_index(input logic [7:0] addr);
        case (addr)
            orbt_pkg::REG_CTRL: reg_index = orbt_pkg::ORBT_IDX_CTRL;
            orbt_pkg::REG_STATUS: reg_index = orbt_pkg::ORBT_IDX_STATUS;
            orbt_pkg::REG_SNAP: reg_index = orbt_pkg::ORBT_IDX_SNAP;
            orbt_pkg::REG_SIGNATURE: reg_index = orbt_pkg::ORBT_IDX_SIGNATURE;
            orbt_pkg::REG_STORED: reg_index = orbt_pkg::ORBT_IDX_STORED;
            orbt_pkg::REG_TEST_OUT: reg_index = orbt_pkg::ORBT_IDX_TEST_OUT;
            default: reg_index = orbt_pkg::ORBT_IDX_NONE;
        endcase
    endfunction : reg_index

    function automatic logic [31:0] apply_strobe(input logic [31:0] old,
                                                 input logic [31:0] wd,
                                                 input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        apply_strobe = res;
    endfunction : apply_strobe

    function automatic logic [15:0] lfsr_step(input logic [15:0] v, input logic [15:0] din);
        lfsr_step = {v[14:0], ^(v & orbt_pkg::LFSR_TAPS)} ^ din;
    endfunction : lfsr_step

    // ------------------------------------------------------------
    // combinational glue
    // ------------------------------------------------------------
    logic ab_edge, ba_edge, tck_rise, tck_fall, test_active, rd_take, wr_fire;
    logic [15:0] pin_snapshot, drive_pattern;
    orbt_pkg::orbt_idx_t rd_idx, wr_idx;
    logic [31:0] wr_word, rd_word;

    assign ab_edge = a_to_b_capture_clock && !s_r.clk_ab_q;
    assign ba_edge = b_to_a_capture_clock && !s_r.clk_ba_q;
    assign tck_rise = test_clock && !s_r.tck_q; // RULE_14
    assign tck_fall = !test_clock && s_r.tck_q; // RULE_14
    assign test_active = test_mode_request && !tap_in_reset_state; // RULE_15
    // self-test loops the test_out register back instead of the pins
    assign pin_snapshot = s_r.selftest ? s_r.test_out : {b_port_bits_in, a_port_bits_in}; // RULE_11
    assign drive_pattern = s_r.output_pseudorandom_patterns_en ? s_r.output_pseudorandom_patterns : s_r.test_out; // RULE_12
    assign rd_take = s_axi_arvalid && s_r.arready;
    assign rd_idx = reg_index(s_axi_araddr);
    assign wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    assign wr_idx = reg_index(s_r.awaddr_q);
    assign wr_word = apply_strobe(32'h0000_0000, s_r.wdata_q, s_r.wstrb_q);

    // snapshot stalls while the queue is full; a second request made meanwhile merges with the pending one
    assign snap_q.push_valid = s_r.sample_pend; // RULE_11
    assign snap_q.push_data = pin_snapshot;
    assign snap_q.pop_ready = rd_take && (rd_idx == orbt_pkg::ORBT_IDX_SNAP);

    always_comb begin
        rd_word = 32'h0000_0000;
        case (rd_idx)
            orbt_pkg::ORBT_IDX_CTRL: begin
                rd_word[orbt_pkg::CTRL_PSA_BIT] = s_r.psa_en;
                rd_word[orbt_pkg::CTRL_OUTPUT_PSEUDORANDOM_PATTERNS_BIT] = s_r.output_pseudorandom_patterns_en;
                rd_word[orbt_pkg::CTRL_SELFTEST_BIT] = s_r.selftest;
            end
            orbt_pkg::ORBT_IDX_STATUS: begin
                rd_word[orbt_pkg::STAT_NOT_EMPTY_BIT] = snap_q.pop_valid;
                rd_word[orbt_pkg::STAT_FULL_BIT] = !snap_q.push_ready;
                rd_word[orbt_pkg::STAT_TEST_BIT] = test_active;
                rd_word[orbt_pkg::STAT_PENDING_BIT] = s_r.sample_pend;
            end
            orbt_pkg::ORBT_IDX_SNAP: begin
                rd_word[15:0] = snap_q.pop_valid ? snap_q.pop_data : 16'h0000;
            end
            orbt_pkg::ORBT_IDX_SIGNATURE: rd_word[15:0] = s_r.sig;
            orbt_pkg::ORBT_IDX_STORED: rd_word[15:0] = {s_r.b_store, s_r.a_store};
            orbt_pkg::ORBT_IDX_TEST_OUT: rd_word[15:0] = s_r.test_out;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.clk_ab_q = a_to_b_capture_clock;
        s_nxt.clk_ba_q = b_to_a_capture_clock;
        s_nxt.tck_q = test_clock;

        if (test_active) begin
            // boundary drives both buses and watches them
            s_nxt.a_out = drive_pattern[7:0]; // RULE_09
            s_nxt.b_out = drive_pattern[15:8]; // RULE_09
            s_nxt.a_oe_n = 1'b0; // RULE_09
            s_nxt.b_oe_n = 1'b0; // RULE_09
            if (s_r.psa_en) begin
                s_nxt.sig = lfsr_step(s_r.sig, {b_port_bits_in, a_port_bits_in}); // RULE_12
            end
            if (s_r.output_pseudorandom_patterns_en) begin
                s_nxt.output_pseudorandom_patterns = lfsr_step(s_r.output_pseudorandom_patterns, 16'h0000); // RULE_12
            end
        end else begin
            // storage ignores enable and flow; no reset on it
            if (ab_edge) begin
                s_nxt.a_store = a_port_bits_in; // RULE_03 RULE_07 RULE_08 RULE_16
            end
            if (ba_edge) begin
                s_nxt.b_store = b_port_bits_in; // RULE_06 RULE_07 RULE_08 RULE_16
            end
            s_nxt.a_oe_n = output_enable_n || flow_a_to_b; // RULE_01 RULE_02 RULE_10
            s_nxt.b_oe_n = output_enable_n || !flow_a_to_b; // RULE_01 RULE_02 RULE_10
            s_nxt.b_out = b_output_source_select ? s_r.a_store : a_port_bits_in; // RULE_04 RULE_05
            s_nxt.a_out = a_output_source_select ? s_r.b_store : b_port_bits_in; // RULE_06
        end

        // serial path follows the tester's clock outside controller reset; in reset it reloads the pin snapshot every cycle
        if (tap_in_reset_state) begin
            s_nxt.scan_sr = pin_snapshot; // RULE_15
            s_nxt.tdo_oe_n = 1'b1; // RULE_15
        end else begin
            if (tck_rise) begin
                s_nxt.scan_sr = test_mode_select ? pin_snapshot
                                                 : {test_data_in, s_r.scan_sr[15:1]}; // RULE_13
            end
            if (tck_fall) begin
                s_nxt.tdo = s_r.scan_sr[0]; // RULE_14
                s_nxt.tdo_oe_n = 1'b0; // RULE_13
            end
        end

        // snapshot queue hand-off; a new request in the same cycle wins
        if (snap_q.push_valid && snap_q.push_ready) begin
            s_nxt.sample_pend = 1'b0;
        end

        // write channel
        if (s_axi_awvalid && s_r.awready) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr_q = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_r.wready) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata_q = s_axi_wdata;
            s_nxt.wstrb_q = s_axi_wstrb;
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (wr_fire) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = (wr_idx == orbt_pkg::ORBT_IDX_NONE) ? orbt_pkg::RESP_SLVERR
                                                              : orbt_pkg::RESP_OKAY;
            case (wr_idx)
                orbt_pkg::ORBT_IDX_CTRL: begin
                    if (s_r.wstrb_q[0]) begin
                        s_nxt.psa_en = wr_word[orbt_pkg::CTRL_PSA_BIT];
                        s_nxt.output_pseudorandom_patterns_en = wr_word[orbt_pkg::CTRL_OUTPUT_PSEUDORANDOM_PATTERNS_BIT];
                        s_nxt.selftest = wr_word[orbt_pkg::CTRL_SELFTEST_BIT];
                        if (wr_word[orbt_pkg::CTRL_SAMPLE_BIT]) begin
                            s_nxt.sample_pend = 1'b1; // RULE_11
                        end
                    end
                end
                orbt_pkg::ORBT_IDX_SIGNATURE: begin
                    s_nxt.sig = 16'(apply_strobe({16'h0000, s_r.sig}, s_r.wdata_q,
                                                 s_r.wstrb_q));
                end
                orbt_pkg::ORBT_IDX_TEST_OUT: begin
                    s_nxt.test_out = 16'(apply_strobe({16'h0000, s_r.test_out}, s_r.wdata_q,
                                                      s_r.wstrb_q));
                end
                default: ;
            endcase
        end
        s_nxt.awready = !s_nxt.aw_got;
        s_nxt.wready = !s_nxt.w_got;

        // read channel
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (rd_take) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rd_word;
            s_nxt.rresp = (rd_idx == orbt_pkg::ORBT_IDX_NONE) ? orbt_pkg::RESP_SLVERR
                                                              : orbt_pkg::RESP_OKAY;
        end
        s_nxt.arready = !s_nxt.rvalid;

        // control state only; the two storage registers keep their contents
        if (!aresetn) begin
            s_nxt = '0;
            s_nxt.a_store = s_r.a_store;
            s_nxt.b_store = s_r.b_store;
            s_nxt.clk_ab_q = a_to_b_capture_clock;
            s_nxt.clk_ba_q = b_to_a_capture_clock;
            s_nxt.tck_q = test_clock;
            s_nxt.a_oe_n = 1'b1;
            s_nxt.b_oe_n = 1'b1;
            s_nxt.tdo_oe_n = 1'b1;
            s_nxt.test_out = orbt_pkg::TEST_OUT_RESET;
            s_nxt.sig = orbt_pkg::SIG_RESET;
            s_nxt.output_pseudorandom_patterns = orbt_pkg::OUTPUT_PSEUDORANDOM_PATTERNS_SEED;
            s_nxt.bresp = orbt_pkg::RESP_OKAY;
            s_nxt.rresp = orbt_pkg::RESP_OKAY;
        end
    end

    // reset acts even while the clock enable is low
    always_ff @(posedge aclk) begin
        if (!aresetn || clk_en) begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign a_port_bits_out = s_r.a_out;
    assign a_port_bits_oe_n = s_r.a_oe_n;
    assign b_port_bits_out = s_r.b_out;
    assign b_port_bits_oe_n = s_r.b_oe_n;
    assign test_data_out = s_r.tdo;
    assign test_data_out_oe_n = s_r.tdo_oe_n;
    assign s_axi_awready = s_r.awready;
    assign s_axi_wready = s_r.wready;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign s_axi_rvalid = s_r.rvalid;
endmodule : orbt_transceiver

// ===== orbt_monitor.sv
module orbt_monitor (
    input logic aclk,
    input logic aresetn,
    input logic clk_en,
    input logic [7:0] a_port_bits_in,
    input logic [7:0] a_port_bits_out,
    input logic a_port_bits_oe_n,
    input logic [7:0] b_port_bits_in,
    input logic [7:0] b_port_bits_out,
    input logic b_port_bits_oe_n,
    input logic output_enable_n,
    input logic flow_a_to_b,
    input logic a_to_b_capture_clock,
    input logic b_to_a_capture_clock,
    input logic b_output_source_select,
    input logic a_output_source_select,
    input logic tap_in_reset_state,
    input logic test_mode_request,
    input logic test_data_out_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---
    // qualifiers
    // ---
    logic nm;
    logic drv;
    // test request only bites once the controller has left reset
    assign nm = clk_en && (!test_mode_request || tap_in_reset_state);
    assign drv = nm && !output_enable_n;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // edge seen only if the previous sample was also taken in normal mode
    sequence ab_cap;
        $past(nm) && nm && $rose(a_to_b_capture_clock);
    endsequence
    sequence ba_cap;
        $past(nm) && nm && $rose(b_to_a_capture_clock);
    endsequence
    // ---
    // properties
    // ---
    AST_ISOLATE: assert property (nm && output_enable_n |=>
        a_port_bits_oe_n && b_port_bits_oe_n) else $error("buses not isolated");
    AST_DIR_AB: assert property (drv && flow_a_to_b |=>
        !b_port_bits_oe_n && a_port_bits_oe_n) else $error("wrong drive side");
    AST_LIVE_AB: assert property (drv && flow_a_to_b && !b_output_source_select |=>
        b_port_bits_out == $past(a_port_bits_in)) else $error("live a data lost");
    AST_LIVE_BA: assert property (drv && !flow_a_to_b && !a_output_source_select |=>
        !a_port_bits_oe_n && a_port_bits_out == $past(b_port_bits_in))
        else $error("live b data lost");
    AST_STORED_AB: assert property (ab_cap ##1 (drv && flow_a_to_b &&
        b_output_source_select) |=> b_port_bits_out == $past(a_port_bits_in, 2))
        else $error("stored a data lost");
    AST_STORED_BA: assert property (ba_cap ##1 (drv && !flow_a_to_b &&
        a_output_source_select) |=> a_port_bits_out == $past(b_port_bits_in, 2))
        else $error("stored b data lost");
    AST_TEST_DRIVE: assert property (clk_en && test_mode_request && !tap_in_reset_state |=>
        !a_port_bits_oe_n && !b_port_bits_oe_n) else $error("test drive missing");
    AST_TAP_RESET: assert property (clk_en && tap_in_reset_state |=> test_data_out_oe_n)
        else $error("serial out driven in reset");
endmodule : orbt_monitor

bind orbt_transceiver orbt_monitor u_monitor (.*);

// ===== orbt_far_bus.sv
module orbt_far_bus (
    input logic [7:0] a_src,
    input logic [7:0] b_src,
    input logic [7:0] a_port_bits_out,
    input logic a_port_bits_oe_n,
    input logic [7:0] b_port_bits_out,
    input logic b_port_bits_oe_n,
    output logic [7:0] a_port_bits_in,
    output logic [7:0] b_port_bits_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // far logic drives any side the block releases, so no side ever floats
    assign a_port_bits_in = a_port_bits_oe_n ? a_src : a_port_bits_out;
    assign b_port_bits_in = b_port_bits_oe_n ? b_src : b_port_bits_out;
endmodule : orbt_far_bus

// ===== orbt_tb.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn, clk_en, output_enable_n, flow_a_to_b, test_clock, test_mode_select;
    logic a_to_b_capture_clock, b_to_a_capture_clock, b_output_source_select;
    logic a_output_source_select, test_data_in, tap_in_reset_state, test_mode_request;
    logic a_port_bits_oe_n, b_port_bits_oe_n, test_data_out, test_data_out_oe_n;
    logic [7:0] a_port_bits_in, a_port_bits_out, b_port_bits_in, b_port_bits_out;
    logic [7:0] a_src, b_src, s_axi_awaddr, s_axi_araddr, av, bv;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [15:0] t, p, v;
    logic [15:0] q[$];
    int num_errors = 0;
    int check_count = 0;
    orbt_transceiver uut (.*);
    orbt_far_bus far_side (.*);
    initial begin
        forever #12.5 aclk = ~aclk;
    end
    // ---
    // helpers
    // ---
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rdr
    task automatic set(input logic [5:0] m);
        {output_enable_n, flow_a_to_b, b_output_source_select, a_output_source_select,
            test_mode_request, tap_in_reset_state} <= m;
        cyc(3);
    endtask : set
    task automatic cap();
        {a_to_b_capture_clock, b_to_a_capture_clock} <= 2'b11;
        cyc(2);
        {a_to_b_capture_clock, b_to_a_capture_clock} <= 2'b00;
        cyc(2);
    endtask : cap
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], ^(s & orbt_pkg::LFSR_TAPS)};
    endfunction : lfsr_next
    initial begin
        #500us;
        num_errors++;
        give_verdict();
    end
    // ---
    // tests
    // ---
    initial begin
        {aresetn, flow_a_to_b, test_clock, a_to_b_capture_clock, b_to_a_capture_clock,
            b_output_source_select, a_output_source_select, tap_in_reset_state,
            test_mode_request, a_src, b_src, s_axi_awvalid, s_axi_wvalid, s_axi_bready,
            s_axi_arvalid, s_axi_rready} = '0;
        {clk_en, output_enable_n, s_axi_wstrb} = 6'h3f;
        void'($urandom(32'h851c9ed3));
        cyc(8);
        aresetn <= 1'b1;
        cyc(2);
        repeat (400) begin
            {output_enable_n, flow_a_to_b, b_output_source_select, a_output_source_select,
                test_mode_request, tap_in_reset_state, a_to_b_capture_clock,
                b_to_a_capture_clock, clk_en, test_clock, test_mode_select, test_data_in,
                a_src, b_src} <= 28'($urandom);
            cyc(1);
        end
        {clk_en, a_to_b_capture_clock, b_to_a_capture_clock, test_clock} <= 4'h8;
        test_mode_select <= 1'b0;
        $display("random traffic done");
        set(6'b100000);
        av = 8'($urandom);
        bv = 8'($urandom);
        {b_src, a_src} <= {bv, av};
        cap();
        rdr(orbt_pkg::REG_STORED);
        chk(rd, {16'h0000, bv, av});
        a_src <= ~av;
        set(6'b011000);
        chk(32'(b_port_bits_out), 32'(av));
        set(6'b010000);
        chk(32'({b_port_bits_oe_n, a_port_bits_oe_n, b_port_bits_out}), 32'({2'b01, ~av}));
        set(6'b000100);
        chk(32'({b_port_bits_oe_n, a_port_bits_oe_n, a_port_bits_out}), 32'({2'b10, bv}));
        set(6'b100100);
        chk(32'({b_port_bits_oe_n, a_port_bits_oe_n}), 32'h3);
        $display("transfer paths done");
        t = 16'($urandom);
        wr(orbt_pkg::REG_TEST_OUT, {16'h0000, t});
        chk(32'(rr), 32'(orbt_pkg::RESP_OKAY));
        set(6'b100010);
        cap();
        chk(32'({b_port_bits_oe_n, a_port_bits_oe_n, b_port_bits_out, a_port_bits_out}), 32'(t));
        wr(orbt_pkg::REG_CTRL, 32'h4);
        cyc(2);
        repeat (4) begin
            p = {b_port_bits_out, a_port_bits_out};
            cyc(1);
            chk(32'({b_port_bits_out, a_port_bits_out}), 32'(lfsr_next(p)));
        end
        wr(orbt_pkg::REG_CTRL, 32'h0);
        set(6'b100000);
        rdr(orbt_pkg::REG_STORED);
        chk(rd, {16'h0000, bv, av});
        $display("test mode done");
        for (int i = 0; i < 4; i++) begin
            v = 16'($urandom);
            {b_src, a_src} <= v;
            q.push_back(v);
            cyc(2);
            wr(orbt_pkg::REG_CTRL, 32'h1);
            cyc(2);
        end
        rdr(orbt_pkg::REG_STATUS);
        chk(32'(rd[1:0]), 32'h3);
        for (int i = 0; i < 4; i++) begin
            rdr(orbt_pkg::REG_SNAP);
            chk(rd, 32'(q.pop_front()));
        end
        rdr(orbt_pkg::REG_SNAP);
        chk(rd, 32'h0);
        rdr(8'h40);
        chk(32'(rr), 32'(orbt_pkg::RESP_SLVERR));
        $display("snapshot fifo done");
        v = 16'($urandom);
        {b_src, a_src} <= v;
        test_clock <= 1'b1;
        set(6'b100001);
        set(6'b100000);
        for (int k = 0; k < 8; k++) begin
            test_clock <= 1'b0;
            cyc(3);
            chk(32'({test_data_out_oe_n, test_data_out}), 32'({1'b0, v[k]}));
            test_clock <= 1'b1;
            cyc(3);
        end
        $display("serial shift done");
        give_verdict();
    end
endmodule : testbench
